// *** bridge_parity_pkg.sv ***
package bridge_parity_pkg;

    // ------------------------------------------------------------
    // bus indices and widths
    // ------------------------------------------------------------
    localparam int unsigned BUS_PRI = 0;
    localparam int unsigned BUS_SEC = 1;
    localparam int unsigned AD_W = 32;
    localparam int unsigned CBE_W = 4;
    localparam int unsigned REG_AW = 8;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CMD_STATUS = 8'h04;
    localparam logic [7:0] OFS_SEC_STATUS = 8'h1C;
    localparam logic [7:0] OFS_BRIDGE_CTRL = 8'h3C;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned BIT_CMD_PRE = 6;
    localparam int unsigned BIT_CMD_SERR_EN = 8;
    localparam int unsigned BIT_ST_DPD = 24;
    localparam int unsigned BIT_ST_SIG_SERR = 30;
    localparam int unsigned BIT_ST_DET = 31;
    localparam int unsigned BIT_BCTL_PRE = 16;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic RST_PRE = 1'b0;
    localparam logic RST_SERR_EN = 1'b0;
    localparam logic RST_STATUS = 1'b0;

    // ------------------------------------------------------------
    // timing: parity error output follows the data transfer
    // ------------------------------------------------------------
    localparam int unsigned PERR_DELAY_CYC = 2;

    // one bus as seen by the error logic, driven by the bus engines
    typedef struct packed {
        logic addr_phase;
        logic data_phase;
        logic [AD_W-1:0] ad;
        logic [CBE_W-1:0] cbe;
        logic par;
        logic claim_hit;
        logic cfg_wr0;
        logic read_rx;
        logic read_return;
        logic posted_wr;
        logic dw_req;
        logic dw_status_ready;
        logic multi_phase;
        logic deliver_dw;
        logic perr_seen;
    } bus_in_t;

    typedef struct packed {
        logic device_select;
        logic target_ready;
        logic stop;
        logic retry;
        logic dw_queue;
        logic dw_done;
        logic cfg_wr_en;
        logic fwd_valid;
        logic [AD_W-1:0] fwd_ad;
        logic [CBE_W-1:0] fwd_cbe;
        logic fwd_par;
        logic parity_error_oe;
    } bus_out_t;

    typedef struct packed {
        logic valid;
        logic held_err;
        logic [AD_W-1:0] addr;
        logic [CBE_W-1:0] cmd;
        logic apar;
        logic [AD_W-1:0] data;
        logic [CBE_W-1:0] be;
        logic dpar;
    } dw_entry_t;

    typedef struct packed {
        logic [AD_W-1:0] addr;
        logic [CBE_W-1:0] cmd;
        logic apar;
        logic ape;
    } addr_cap_t;

endpackage

// *** bridge_parity_error_handler.sv ***
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
module bridge_parity_error_handler (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input bridge_parity_pkg::bus_in_t primary_bus_i,
    input bridge_parity_pkg::bus_in_t secondary_bus_i,
    output bridge_parity_pkg::bus_out_t primary_bus_o,
    output bridge_parity_pkg::bus_out_t secondary_bus_o,
    output logic primary_parity_error_out_n_o,
    output logic secondary_parity_error_out_n_o,
    output logic primary_system_error_out_n_o,
    output logic primary_system_error_out_oe_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic pre_pri;
        logic pre_sec;
        logic serr_en;
        logic [1:0] det;
        logic [1:0] dpd;
        logic sig_serr;
        logic [31:0] rdata;
        logic [1:0][1:0] perr_pipe;
        logic [1:0] serr_pipe;
        bridge_parity_pkg::addr_cap_t [1:0] acap;
        bridge_parity_pkg::dw_entry_t [1:0] entry;
        logic [1:0] fwd_valid;
        logic [1:0][bridge_parity_pkg::AD_W-1:0] fwd_ad;
        logic [1:0][bridge_parity_pkg::CBE_W-1:0] fwd_cbe;
        logic [1:0] fwd_par;
    } state_t;

    state_t state_reg;
    state_t state_next;

    bridge_parity_pkg::bus_in_t [1:0] bus_in;
    bridge_parity_pkg::bus_out_t [1:0] bus_out;
    logic [1:0] perr_fire;
    logic [1:0] serr_fire;
    logic [1:0] det_set;
    logic [1:0] dpd_set;
    logic [1:0] par_err;
    logic [1:0] pre;
    logic [1:0] dw_match;
    logic [1:0] held_set;
    logic [31:0] status_word;
    logic [31:0] sec_word;
    logic [31:0] bctl_word;
    logic [31:0] wmask;

    assign bus_in[bridge_parity_pkg::BUS_PRI] = primary_bus_i;
    assign bus_in[bridge_parity_pkg::BUS_SEC] = secondary_bus_i;
    assign primary_bus_o = bus_out[bridge_parity_pkg::BUS_PRI];
    assign secondary_bus_o = bus_out[bridge_parity_pkg::BUS_SEC];

    assign pre[bridge_parity_pkg::BUS_PRI] = state_reg.pre_pri;
    assign pre[bridge_parity_pkg::BUS_SEC] = state_reg.pre_sec;

    // ------------------------------------------------------------
    // register read view
    // ------------------------------------------------------------
    always_comb begin
        status_word = '0;
        status_word[bridge_parity_pkg::BIT_CMD_PRE] = state_reg.pre_pri;
        status_word[bridge_parity_pkg::BIT_CMD_SERR_EN] = state_reg.serr_en;
        status_word[bridge_parity_pkg::BIT_ST_DPD] = state_reg.dpd[bridge_parity_pkg::BUS_PRI];
        status_word[bridge_parity_pkg::BIT_ST_SIG_SERR] = state_reg.sig_serr;
        status_word[bridge_parity_pkg::BIT_ST_DET] = state_reg.det[bridge_parity_pkg::BUS_PRI];
        sec_word = '0;
        sec_word[bridge_parity_pkg::BIT_ST_DPD] = state_reg.dpd[bridge_parity_pkg::BUS_SEC];
        sec_word[bridge_parity_pkg::BIT_ST_DET] = state_reg.det[bridge_parity_pkg::BUS_SEC];
        bctl_word = '0;
        bctl_word[bridge_parity_pkg::BIT_BCTL_PRE] = state_reg.pre_sec;
        wmask = reg_wr_i ? reg_wdata_i : 32'h0000_0000;
    end

    // ------------------------------------------------------------
    // per-bus parity checking and event decode
    // ------------------------------------------------------------
    always_comb begin
        for (int b = 0; b < 2; b++) begin
            // even parity: ad, cbe and par together carry an even count of ones
            par_err[b] = ^{bus_in[b].ad, bus_in[b].cbe, bus_in[b].par};
            dw_match[b] = state_reg.entry[b].valid
                && (state_reg.entry[b].addr == state_reg.acap[b].addr)
                && (state_reg.entry[b].cmd == state_reg.acap[b].cmd)
                && (state_reg.entry[b].data == bus_in[b].ad)
                && (state_reg.entry[b].be == bus_in[b].cbe);
        end
    end

    always_comb begin
        int o;
        o = 0;
        state_next = state_reg;
        perr_fire = '0;
        serr_fire = '0;
        det_set = '0;
        dpd_set = '0;
        held_set = '0;
        bus_out = '0;

        for (int b = 0; b < 2; b++) begin
            o = 1 - b;

            // --------------------------------------------------------
            // address phase
            // --------------------------------------------------------
            if (bus_in[b].addr_phase) begin
                state_next.acap[b].addr = bus_in[b].ad;
                state_next.acap[b].cmd = bus_in[b].cbe;
                state_next.acap[b].apar = bus_in[b].par;
                state_next.acap[b].ape = par_err[b];
                if (par_err[b]) begin
                    det_set[b] = 1'b1;
                    if (pre[b] && state_reg.serr_en) begin
                        serr_fire[b] = 1'b1;
                    end
                end
                // claiming is blocked only while response is enabled
                bus_out[b].device_select = bus_in[b].claim_hit && !(par_err[b] && pre[b]);
            end

            // --------------------------------------------------------
            // data phase
            // --------------------------------------------------------
            if (bus_in[b].data_phase) begin
                if (bus_in[b].cfg_wr0 && b == bridge_parity_pkg::BUS_PRI) begin
                    bus_out[b].target_ready = 1'b1;
                    bus_out[b].cfg_wr_en = 1'b1;
                    if (par_err[b]) begin
                        det_set[b] = 1'b1;
                        perr_fire[b] = pre[b];
                    end
                end
                if (bus_in[b].read_rx && par_err[b]) begin
                    det_set[b] = 1'b1;
                    if (pre[b]) begin
                        perr_fire[b] = 1'b1;
                        dpd_set[b] = 1'b1;
                    end
                end
                if (bus_in[b].posted_wr && par_err[b]) begin
                    det_set[b] = 1'b1;
                end
                // an initiator reporting bad read data is left to handle it
                if (bus_in[b].read_return) begin
                    bus_out[b].target_ready = 1'b1;
                end

                // delayed write as target on bus b
                if (bus_in[b].dw_req) begin
                    if (par_err[b]) begin
                        det_set[b] = 1'b1;
                    end
                    if (!state_reg.entry[b].valid) begin
                        if (par_err[b] && pre[b]) begin
                            bus_out[b].target_ready = 1'b1;
                            bus_out[b].stop = bus_in[b].multi_phase;
                            perr_fire[b] = 1'b1;
                        end else begin
                            bus_out[b].retry = 1'b1;
                            bus_out[b].dw_queue = 1'b1;
                            state_next.entry[b].valid = 1'b1;
                            state_next.entry[b].held_err = 1'b0;
                            state_next.entry[b].addr = state_reg.acap[b].addr;
                            state_next.entry[b].cmd = state_reg.acap[b].cmd;
                            state_next.entry[b].apar = state_reg.acap[b].apar;
                            state_next.entry[b].data = bus_in[b].ad;
                            state_next.entry[b].be = bus_in[b].cbe;
                            state_next.entry[b].dpar = bus_in[b].par;
                        end
                    end else if (dw_match[b] && bus_in[b].dw_status_ready) begin
                        bus_out[b].target_ready = 1'b1;
                        if (par_err[b]) begin
                            // status kept back, entry stays queued
                            perr_fire[b] = pre[b];
                        end else begin
                            bus_out[b].dw_done = 1'b1;
                            state_next.entry[b].valid = 1'b0;
                            if (state_reg.entry[b].held_err && state_reg.pre_pri && state_reg.pre_sec) begin
                                perr_fire[b] = 1'b1;
                            end
                        end
                    end else begin
                        bus_out[b].retry = 1'b1;
                    end
                end
            end

            // forwarding copy of either phase; parity passes as seen, never regenerated
            state_next.fwd_valid[o] = bus_in[b].addr_phase | bus_in[b].data_phase;
            if (bus_in[b].addr_phase | bus_in[b].data_phase) begin
                state_next.fwd_ad[o] = bus_in[b].ad;
                state_next.fwd_cbe[o] = bus_in[b].cbe;
                state_next.fwd_par[o] = bus_in[b].par;
            end

            // --------------------------------------------------------
            // target on bus b reports an error on delayed write data
            // --------------------------------------------------------
            if (bus_in[b].deliver_dw && bus_in[b].perr_seen) begin
                if (pre[b]) begin
                    dpd_set[b] = 1'b1;
                end
                held_set[o] = 1'b1;
            end
        end

        for (int b = 0; b < 2; b++) begin
            // a held error survives until its entry completes
            if (held_set[b] && state_next.entry[b].valid) begin
                state_next.entry[b].held_err = 1'b1;
            end
            bus_out[b].fwd_valid = state_reg.fwd_valid[b];
            bus_out[b].fwd_ad = state_reg.fwd_ad[b];
            bus_out[b].fwd_cbe = state_reg.fwd_cbe[b];
            bus_out[b].fwd_par = state_reg.fwd_par[b];
            bus_out[b].parity_error_oe = state_reg.perr_pipe[b][1];
            state_next.perr_pipe[b][0] = perr_fire[b];
            state_next.perr_pipe[b][1] = state_reg.perr_pipe[b][0];
        end
        state_next.serr_pipe[0] = |serr_fire;
        state_next.serr_pipe[1] = state_reg.serr_pipe[0];

        // --------------------------------------------------------
        // register writes; hardware set wins over a software clear
        // --------------------------------------------------------
        if (reg_wr_i && reg_addr_i == bridge_parity_pkg::OFS_CMD_STATUS) begin
            state_next.pre_pri = reg_wdata_i[bridge_parity_pkg::BIT_CMD_PRE];
            state_next.serr_en = reg_wdata_i[bridge_parity_pkg::BIT_CMD_SERR_EN];
            state_next.det[0] = state_reg.det[0] & ~wmask[bridge_parity_pkg::BIT_ST_DET];
            state_next.dpd[0] = state_reg.dpd[0] & ~wmask[bridge_parity_pkg::BIT_ST_DPD];
            state_next.sig_serr = state_reg.sig_serr & ~wmask[bridge_parity_pkg::BIT_ST_SIG_SERR];
        end
        if (reg_wr_i && reg_addr_i == bridge_parity_pkg::OFS_SEC_STATUS) begin
            state_next.det[1] = state_reg.det[1] & ~wmask[bridge_parity_pkg::BIT_ST_DET];
            state_next.dpd[1] = state_reg.dpd[1] & ~wmask[bridge_parity_pkg::BIT_ST_DPD];
        end
        if (reg_wr_i && reg_addr_i == bridge_parity_pkg::OFS_BRIDGE_CTRL) begin
            state_next.pre_sec = reg_wdata_i[bridge_parity_pkg::BIT_BCTL_PRE];
        end
        state_next.det = state_next.det | det_set;
        state_next.dpd = state_next.dpd | dpd_set;
        if (|serr_fire) begin
            state_next.sig_serr = 1'b1;
        end

        // --------------------------------------------------------
        // register read, data valid the cycle after the strobe
        // --------------------------------------------------------
        state_next.rdata = 32'h0000_0000;
        if (reg_rd_i) begin
            case (reg_addr_i)
                bridge_parity_pkg::OFS_CMD_STATUS: begin
                    state_next.rdata = status_word;
                end
                bridge_parity_pkg::OFS_SEC_STATUS: begin
                    state_next.rdata = sec_word;
                end
                bridge_parity_pkg::OFS_BRIDGE_CTRL: begin
                    state_next.rdata = bctl_word;
                end
                default: begin
                    state_next.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_reg <= '0;
            state_reg.pre_pri <= bridge_parity_pkg::RST_PRE;
            state_reg.pre_sec <= bridge_parity_pkg::RST_PRE;
            state_reg.serr_en <= bridge_parity_pkg::RST_SERR_EN;
            state_reg.det <= {2{bridge_parity_pkg::RST_STATUS}};
            state_reg.dpd <= {2{bridge_parity_pkg::RST_STATUS}};
            state_reg.sig_serr <= bridge_parity_pkg::RST_STATUS;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // outputs; error pins are driven low only while enabled
    // ------------------------------------------------------------
    assign reg_rdata_o = state_reg.rdata;
    assign primary_parity_error_out_n_o = ~state_reg.perr_pipe[0][1];
    assign secondary_parity_error_out_n_o = ~state_reg.perr_pipe[1][1];
    assign primary_system_error_out_n_o = ~state_reg.serr_pipe[1];
    assign primary_system_error_out_oe_o = state_reg.serr_pipe[1];

endmodule

// *** bus_agent.sv ***
`timescale 1ns/1ps
module bus_agent (
    output bridge_parity_pkg::bus_in_t bus_o
);
    initial bus_o = '0;

    // even parity over address/data and command lines; bad flips it on purpose
    task automatic put(input logic a, input logic [31:0] ad, input logic [3:0] cbe, input logic bad,
                       input logic [9:0] fl);
        bus_o <= {a, ~a, ad, cbe, (^{ad, cbe}) ^ bad, fl};
    endtask

    // a released bus must not keep showing its last value
    task automatic rel();
        bus_o <= {2'h0, ~bus_o.ad, ~bus_o.cbe, ~bus_o.par, 10'h000};
    endtask
endmodule

// *** bridge_parity_error_handler_props.sv ***
`timescale 1ns/1ps
module bridge_parity_error_handler_props (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input bridge_parity_pkg::bus_in_t primary_bus_i,
    input bridge_parity_pkg::bus_in_t secondary_bus_i,
    input bridge_parity_pkg::bus_out_t primary_bus_o,
    input bridge_parity_pkg::bus_out_t secondary_bus_o,
    input wire logic primary_parity_error_out_n_o,
    input wire logic secondary_parity_error_out_n_o,
    input wire logic primary_system_error_out_n_o,
    input wire logic primary_system_error_out_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);

    // ------------------------------------------------------------
    // shadow of the enables, rebuilt from register writes
    // ------------------------------------------------------------
    logic pre_p_reg, pre_s_reg, serr_en_reg;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pre_p_reg <= 1'h0;
            pre_s_reg <= 1'h0;
            serr_en_reg <= 1'h0;
        end else if (reg_wr_i) begin
            if (reg_addr_i == bridge_parity_pkg::OFS_CMD_STATUS) begin
                pre_p_reg <= reg_wdata_i[bridge_parity_pkg::BIT_CMD_PRE];
                serr_en_reg <= reg_wdata_i[bridge_parity_pkg::BIT_CMD_SERR_EN];
            end
            if (reg_addr_i == bridge_parity_pkg::OFS_BRIDGE_CTRL) begin
                pre_s_reg <= reg_wdata_i[bridge_parity_pkg::BIT_BCTL_PRE];
            end
        end
    end
    wire pe_p = ^{primary_bus_i.ad, primary_bus_i.cbe, primary_bus_i.par};
    wire pe_s = ^{secondary_bus_i.ad, secondary_bus_i.cbe, secondary_bus_i.par};
    wire ape_p = primary_bus_i.addr_phase & pe_p & pre_p_reg;
    wire ape_s = secondary_bus_i.addr_phase & pe_s & pre_s_reg;
    wire serr_fire = (ape_p | ape_s) & serr_en_reg;

    AST_PRI_NO_CLAIM: assert property (ape_p |-> !primary_bus_o.device_select) else $error("primary claimed bad address");
    AST_SEC_NO_CLAIM: assert property (ape_s |-> !secondary_bus_o.device_select) else $error("secondary claimed bad address");
    AST_PRI_CLAIM: assert property (primary_bus_i.addr_phase && primary_bus_i.claim_hit && !ape_p
        |-> primary_bus_o.device_select) else $error("primary hit not claimed");
    AST_SERR_FIRE: assert property (serr_fire |-> ##2 (!primary_system_error_out_n_o && primary_system_error_out_oe_o))
        else $error("system error missing");
    AST_SERR_CAUSE: assert property (!primary_system_error_out_n_o |-> $past(serr_fire, 2))
        else $error("system error without cause");
    AST_PERR_RD_PRI: assert property (primary_bus_i.data_phase && primary_bus_i.read_rx && pe_p && pre_p_reg
        |-> ##2 !primary_parity_error_out_n_o) else $error("primary read parity pin missing");
    AST_PERR_RD_SEC: assert property (secondary_bus_i.data_phase && secondary_bus_i.read_rx && pe_s && pre_s_reg
        |-> ##2 !secondary_parity_error_out_n_o) else $error("secondary read parity pin missing");
    AST_FWD_P2S: assert property (primary_bus_i.data_phase |=> secondary_bus_o.fwd_valid
        && secondary_bus_o.fwd_ad == $past(primary_bus_i.ad) && secondary_bus_o.fwd_par == $past(primary_bus_i.par))
        else $error("forwarded phase differs");
    AST_CFG_STORE: assert property (primary_bus_i.data_phase && primary_bus_i.cfg_wr0 |-> primary_bus_o.cfg_wr_en)
        else $error("config write not stored");

    cover property (serr_fire);
    cover property (primary_bus_i.data_phase && primary_bus_i.cfg_wr0 && pe_p);
    cover property (secondary_bus_i.data_phase && secondary_bus_i.read_rx && pe_s && pre_s_reg);
endmodule

bind bridge_parity_error_handler bridge_parity_error_handler_props props_i (.clk_i, .srst_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .primary_bus_i, .secondary_bus_i, .primary_bus_o, .secondary_bus_o,
    .primary_parity_error_out_n_o, .secondary_parity_error_out_n_o, .primary_system_error_out_n_o,
    .primary_system_error_out_oe_o);

// *** test_bridge_parity_error_handler.sv ***
`timescale 1ns/1ps
module test_bridge_parity_error_handler;
    localparam logic [9:0] F_CLAIM = 10'h200;
    localparam logic [9:0] F_CFG = 10'h100;
    localparam logic [9:0] F_RX = 10'h080;
    localparam logic [9:0] F_DW = 10'h010;
    localparam logic [9:0] F_RDY = 10'h008;
    localparam logic [9:0] F_MULTI = 10'h004;
    logic clk_i = 1'h0;
    logic srst_i = 1'h1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'h0;
    logic reg_rd_i = 1'h0;
    wire [31:0] reg_rdata_o;
    wire bridge_parity_pkg::bus_in_t bi [2];
    wire bridge_parity_pkg::bus_out_t bo [2];
    wire [1:0] perr_n;
    wire serr_n, serr_oe;
    int err_count = 0;
    int checks = 0;
    logic [31:0] rv, ad, w;
    logic b, pre, se, bad;

    always #2.5 clk_i = ~clk_i;

    bus_agent pri_agent (.bus_o(bi[0]));
    bus_agent sec_agent (.bus_o(bi[1]));
    bridge_parity_error_handler bridge_parity_error_handler_i (.clk_i(clk_i), .srst_i(srst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .primary_bus_i(bi[0]), .secondary_bus_i(bi[1]), .primary_bus_o(bo[0]),
        .secondary_bus_o(bo[1]), .primary_parity_error_out_n_o(perr_n[0]),
        .secondary_parity_error_out_n_o(perr_n[1]), .primary_system_error_out_n_o(serr_n),
        .primary_system_error_out_oe_o(serr_oe));

    // ------------------------------------------------------------
    // check, register and bus tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'h1;
        @(posedge clk_i);
        reg_wr_i <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'h1;
        @(posedge clk_i);
        reg_rd_i <= 1'h0;
        #1 d = reg_rdata_o;
    endtask
    // one phase on bus bb, outputs settled on return
    task automatic ph(input logic bb, input logic a, input logic [31:0] d, input logic [3:0] c, input logic bd,
                      input logic [9:0] fl);
        @(posedge clk_i);
        if (bb) sec_agent.put(a, d, c, bd, fl);
        else pri_agent.put(a, d, c, bd, fl);
        #1;
    endtask
    task automatic rel();
        @(posedge clk_i);
        pri_agent.rel();
        sec_agent.rel();
    endtask
    // enables set, all sticky status cleared
    task automatic setup(input logic p, input logic s);
        wr(bridge_parity_pkg::OFS_CMD_STATUS, {23'h0, s, 1'h0, p, 6'h00} | 32'hC100_0000);
        wr(bridge_parity_pkg::OFS_SEC_STATUS, 32'h8100_0000);
        wr(bridge_parity_pkg::OFS_BRIDGE_CTRL, {15'h0, p, 16'h0000});
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clk_i);
        err_count++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'h84C4));
        repeat (20) @(posedge clk_i);
        srst_i <= 1'h0;
        wr(bridge_parity_pkg::OFS_BRIDGE_CTRL, 32'hFFFF_FFFF);
        rd(bridge_parity_pkg::OFS_BRIDGE_CTRL, rv);
        chk("bctl_pre", 32'h0001_0000, rv & 32'h0001_0000);
        wr(8'hF0, 32'hFFFF_FFFF);
        rd(8'hF0, rv);
        chk("unmapped", 32'h0, rv);
        $display("test registers done");
        // address phases: every mix of bus, enables and parity, random commands
        for (int i = 0; i < 16; i++) begin
            {bad, se, pre, b} = i[3:0];
            setup(pre, se);
            ph(b, 1'h1, $urandom(), 4'($urandom()), bad, F_CLAIM);
            chk("device_select", {31'h0, ~(bad & pre)}, {31'h0, bo[b].device_select});
            rel();
            @(posedge clk_i);
            #1;
            chk("system_error_n", {31'h0, ~(bad & pre & se)}, {31'h0, serr_n});
            chk("system_error_oe", {31'h0, bad & pre & se}, {31'h0, serr_oe});
            rd(bridge_parity_pkg::OFS_CMD_STATUS, rv);
            chk("pri_status", {bad & ~b, bad & pre & se, 30'h0}, rv & 32'hC000_0000);
            rd(bridge_parity_pkg::OFS_SEC_STATUS, rv);
            chk("sec_status", {bad & b, 31'h0}, rv & 32'h8000_0000);
        end
        $display("test address parity done");
        for (int i = 0; i < 8; i++) begin
            {bad, pre, b} = i[2:0];
            setup(pre, 1'h0);
            ad = $urandom();
            ph(b, 1'h0, ad, 4'h0, bad, F_RX);
            rel();
            #1;
            chk("fwd_ad", ad, bo[~b].fwd_ad);
            chk("fwd_par", {30'h0, 1'h1, (^ad) ^ bad}, {30'h0, bo[~b].fwd_valid, bo[~b].fwd_par});
            @(posedge clk_i);
            #1;
            chk("read_perr_n", {28'h0, b & bad & pre, ~b & bad & pre, ~(b & bad & pre), ~(~b & bad & pre)},
                {28'h0, bo[1].parity_error_oe, bo[0].parity_error_oe, perr_n});
            rd(b ? bridge_parity_pkg::OFS_SEC_STATUS : bridge_parity_pkg::OFS_CMD_STATUS, rv);
            chk("read_status", {bad, 6'h00, bad & pre, 24'h0}, rv & 32'h8100_0000);
        end
        $display("test read data done");
        for (int i = 0; i < 2; i++) begin
            pre = i[0];
            setup(pre, 1'h0);
            ph(1'h0, 1'h1, $urandom(), 4'hB, 1'h0, F_CLAIM);
            ph(1'h0, 1'h0, $urandom(), 4'h0, 1'h1, F_CLAIM | F_CFG);
            chk("cfg_wr_en", 32'h1, {31'h0, bo[0].cfg_wr_en});
            rel();
            @(posedge clk_i);
            #1;
            chk("cfg_perr_n", {31'h0, ~pre}, {31'h0, perr_n[0]});
            rd(bridge_parity_pkg::OFS_CMD_STATUS, rv);
            chk("cfg_detected", 32'h8000_0000, rv & 32'h8000_0000);
        end
        $display("test config write done");
        ad = $urandom();
        w = $urandom();
        for (int i = 0; i < 2; i++) begin
            pre = ~i[0];
            setup(pre, 1'h0);
            ph(1'h0, 1'h1, ad, 4'h7, 1'h0, F_CLAIM);
            ph(1'h0, 1'h0, w, 4'h0, 1'h1, F_CLAIM | F_DW | F_MULTI);
            chk("dw_handshake", {28'h0, pre, pre, ~pre, ~pre},
                {28'h0, bo[0].target_ready, bo[0].stop, bo[0].retry, bo[0].dw_queue});
            rel();
            @(posedge clk_i);
            #1;
            chk("dw_perr_n", {31'h0, ~pre}, {31'h0, perr_n[0]});
            rd(bridge_parity_pkg::OFS_CMD_STATUS, rv);
            chk("dw_detected", 32'h8000_0000, rv & 32'h8000_0000);
        end
        setup(1'h1, 1'h0);
        ph(1'h1, 1'h0, $urandom(), 4'h0, 1'h0, 10'h003);
        // repeat of the queued write with parity now good still matches
        ph(1'h0, 1'h1, ad, 4'h7, 1'h0, F_CLAIM);
        ph(1'h0, 1'h0, w, 4'h0, 1'h0, F_CLAIM | F_DW | F_RDY);
        chk("dw_done", 32'h3, {30'h0, bo[0].target_ready, bo[0].dw_done});
        rel();
        @(posedge clk_i);
        #1;
        chk("held_perr_n", 32'h0, {31'h0, perr_n[0]});
        rd(bridge_parity_pkg::OFS_SEC_STATUS, rv);
        chk("held_dpd", 32'h0100_0000, rv & 32'h0100_0000);
        $display("test delayed write done");
        tally_and_finish();
    end
endmodule
